// file: bench/sfd_spi_partner.sv
// sfd_spi_partner: behavioural spi slave facing the port in master mode.
// assumes it is selected only while the port drives sck; mode set by the bench.
`timescale 1ns/1ns
`default_nettype none
module sfd_spi_partner (
	input wire logic sck_i, // sck wire
	input wire logic sel_i, // selected while port drives sck
	input wire logic mosi_i, // mosi wire
	input wire logic [1:0] mode_i, // transfer mode
	input wire logic [7:0] tx_i, // next byte to return
	output logic miso_o, // miso drive
	output logic [7:0] rx_o // last whole byte
);
	logic [7:0] sh = 8'h00;
	logic [7:0] acc = 8'h00;
	int cnt = 0;
	initial rx_o = 8'h00;
	// released line shows the inverse, never a stale bit
	assign miso_o = sel_i ? sh[7] : ~sh[7];
	// new byte staged only between bytes
	always @(tx_i) begin
		if (cnt == 0) begin
			sh = tx_i;
		end
	end
	always @(sck_i) begin
		if (sel_i && ((sck_i ^ mode_i[1]) ^ mode_i[0])) begin
			acc = {acc[6:0], mosi_i};
			cnt++;
			if (cnt == 8) begin
				rx_o = acc;
				sh = tx_i;
				cnt = 0;
			end
		end else if (sel_i && cnt != 0) begin
			// no shift before first sample, so bit 7 leads
			sh = {sh[6:0], 1'b0};
		end
	end
endmodule // sfd_spi_partner
`default_nettype wire

// file: bench/sfd_spi_port_tb_top.sv
// sfd_spi_port_tb_top: self-checking bench for the serial port block.
// assumes the partner model on the serial pins; the bench is bus master.
`timescale 1ns/1ns
`default_nettype none
module sfd_spi_port_tb_top;
	localparam logic [4:0] A_CA = {sfd_pkg::IDX_CTRLA, 2'b00};
	localparam logic [4:0] A_CB = {sfd_pkg::IDX_CTRLB, 2'b00};
	localparam logic [4:0] A_IE = {sfd_pkg::IDX_IRQEN, 2'b00};
	localparam logic [4:0] A_FL = {sfd_pkg::IDX_FLAGS, 2'b00};
	localparam logic [4:0] A_DT = {sfd_pkg::IDX_DATA, 2'b00};
	localparam logic [7:0] SB = 8'hB3;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic irq_ack = 1'b0;
	logic [4:0] adr = 5'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack, irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, pmiso;
	logic tsck = 1'b0;
	logic sel_n = 1'b1;
	logic tmosi = 1'b0;
	logic [1:0] pmode = 2'h0;
	logic [7:0] ptx = 8'h00;
	logic [7:0] prx, q;
	int num_errors = 0;
	int tests_run = 0;
	// pin levels resolved from the port's drive enables
	wire sck = sck_oe ? sck_o : tsck;
	wire mosi = mosi_oe ? mosi_o : tmosi;
	wire miso = miso_oe ? miso_o : pmiso;
	always #5 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////////////
	sfd_spi_port #(.HALF_DIV(4)) sfd_spi_port_inst (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .irq_ack_i(irq_ack),
		.sck_i(sck), .sck_o(sck_o), .sck_oe_o(sck_oe), .sel_n_i(sel_n), .mosi_i(mosi),
		.mosi_o(mosi_o), .mosi_oe_o(mosi_oe), .miso_i(miso), .miso_o(miso_o),
		.miso_oe_o(miso_oe));
	sfd_spi_partner sfd_spi_partner_inst (.sck_i(sck), .sel_i(sck_oe), .mosi_i(mosi),
		.mode_i(pmode), .tx_i(ptx), .miso_o(pmiso), .rx_o(prx));
	////////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one classic cycle; waits for ack and checks it arrives two edges after the strobe
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1);
		chk(8'(n), 8'h02);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// poll flags until a bit shows, bounded
	task automatic wflag(input logic [7:0] m);
		int n;
		n = 0;
		do begin
			bus(1'b0, A_FL, 8'h00);
			n++;
		end while ((q & m) == 8'h00 && n < 100);
		chk(q & m, m);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		bus(1'b0, A_IE, 8'h00);
		chk(q, 8'h00);
		bus(1'b0, A_FL, 8'h00);
		chk(q, 8'h00);
		bus(1'b0, A_DT, 8'h00);
		chk(q, 8'h00);
		bus(1'b1, 5'h14, 8'hA5);
		bus(1'b0, 5'h14, 8'h00);
		chk(q, 8'h00);
		bus(1'b1, A_IE, 8'hF1);
		bus(1'b0, A_IE, 8'h00);
		chk(q, 8'h01);
		bus(1'b1, A_IE, 8'h00);
	endtask
	task automatic t_modes;
		bus(1'b1, A_CA, 8'h20);
		for (int m = 0; m < 4; m++) begin
			pmode <= 2'(m);
			ptx <= 8'h3C + 8'(m);
			bus(1'b1, A_CB, 8'(m));
			repeat (4) @(posedge clk_i);
			chk({7'h0, sck_o}, 8'(m >> 1));
			chk({7'h0, sck_oe}, 8'h01);
			bus(1'b1, A_DT, 8'hC5 ^ 8'(m));
			wflag(8'h80);
			bus(1'b0, A_DT, 8'h00);
			chk(q, 8'h3C + 8'(m));
			chk(prx, 8'hC5 ^ 8'(m));
			bus(1'b0, A_FL, 8'h00);
			chk(q, 8'h00);
		end
		pmode <= 2'h0;
		bus(1'b1, A_CB, 8'h00);
	endtask
	task automatic t_irq;
		int n;
		n = 0;
		bus(1'b1, A_IE, 8'h01);
		bus(1'b1, A_DT, 8'h96);
		while (irq !== 1'b1 && n < 200) begin
			@(posedge clk_i);
			n++;
		end
		chk({7'h0, irq}, 8'h01);
		irq_ack <= 1'b1;
		@(posedge clk_i);
		irq_ack <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk({7'h0, irq}, 8'h00);
		bus(1'b0, A_FL, 8'h00);
		chk(q, 8'h00);
		bus(1'b1, A_IE, 8'h00);
	endtask
	task automatic t_coll;
		bus(1'b1, A_DT, 8'h81);
		bus(1'b1, A_DT, 8'h7E);
		wflag(8'h80);
		chk(q, 8'hC0);
		chk(prx, 8'h81);
		bus(1'b0, A_DT, 8'h00);
		bus(1'b0, A_FL, 8'h00);
		chk(q, 8'h00);
	endtask
	task automatic t_fall;
		bus(1'b1, A_CB, 8'h04);
		bus(1'b1, A_CA, 8'h20);
		sel_n <= 1'b0;
		repeat (10) @(posedge clk_i);
		bus(1'b0, A_CA, 8'h00);
		chk(q, 8'h20);
		sel_n <= 1'b1;
		repeat (10) @(posedge clk_i);
		bus(1'b1, A_CB, 8'h00);
		bus(1'b0, A_CA, 8'h00);
		chk(q, 8'h20);
		sel_n <= 1'b0;
		repeat (10) @(posedge clk_i);
		bus(1'b0, A_CA, 8'h00);
		chk(q, 8'h00);
		bus(1'b0, A_FL, 8'h00);
		chk(q, 8'h80);
		bus(1'b0, A_DT, 8'h00);
		sel_n <= 1'b1;
		bus(1'b1, A_CB, 8'h80);
		bus(1'b1, A_CA, 8'h20);
		sel_n <= 1'b0;
		repeat (10) @(posedge clk_i);
		bus(1'b0, A_FL, 8'h00);
		chk(q & 8'h10, 8'h10);
		bus(1'b1, A_FL, 8'h10);
		bus(1'b0, A_FL, 8'h00);
		chk(q & 8'h10, 8'h00);
		sel_n <= 1'b1;
	endtask
	// bench as master; half period kept long for the pin synchronisers
	task automatic t_slave;
		logic [7:0] got;
		bus(1'b1, A_CB, 8'h00);
		bus(1'b1, A_CA, 8'h00);
		bus(1'b1, A_DT, 8'h5A);
		repeat (8) @(posedge clk_i);
		chk({7'h0, sck_oe}, 8'h00);
		sel_n <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			tmosi <= SB[i];
			repeat (16) @(posedge clk_i);
			got[i] = miso;
			tsck <= 1'b1;
			repeat (16) @(posedge clk_i);
			tsck <= 1'b0;
		end
		repeat (16) @(posedge clk_i);
		sel_n <= 1'b1;
		chk(got, 8'h5A);
		bus(1'b0, A_FL, 8'h00);
		chk(q, 8'h80);
		bus(1'b0, A_DT, 8'h00);
		chk(q, SB);
	endtask
	task automatic t_buf;
		bus(1'b1, A_CA, 8'h20);
		bus(1'b1, A_CB, 8'h80);
		bus(1'b1, A_IE, 8'h80);
		bus(1'b0, A_IE, 8'h00);
		chk(q, 8'h80);
		ptx <= 8'h11;
		bus(1'b1, A_DT, 8'h21);
		wflag(8'h40);
		chk(q, 8'hE0);
		chk({7'h0, irq}, 8'h01);
		bus(1'b1, A_FL, 8'h40);
		bus(1'b0, A_FL, 8'h00);
		chk(q, 8'hA0);
		bus(1'b0, A_DT, 8'h00);
		chk(q, 8'h11);
		bus(1'b0, A_FL, 8'h00);
		chk(q, 8'h20);
		chk({7'h0, irq}, 8'h00);
		bus(1'b1, A_IE, 8'h20);
		repeat (2) @(posedge clk_i);
		chk({7'h0, irq}, 8'h01);
		bus(1'b1, A_IE, 8'h00);
		for (int k = 0; k < 4; k++) begin
			ptx <= 8'h31 + 8'(k);
			bus(1'b1, A_DT, 8'h00);
			wflag(8'h40);
			if (k == 2) chk(q & 8'h01, 8'h00);
			bus(1'b1, A_FL, 8'h40);
		end
		bus(1'b0, A_FL, 8'h00);
		chk(q & 8'h01, 8'h01);
		bus(1'b0, A_DT, 8'h00);
		chk(q, 8'h31);
		bus(1'b0, A_FL, 8'h00);
		chk(q & 8'h01, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////////////
	// single place where the run ends
	task automatic report_and_stop;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// main sequence after ten reset cycles
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs;
		t_modes;
		t_irq;
		t_coll;
		t_fall;
		t_slave;
		t_buf;
		report_and_stop;
	end
	// watchdog well beyond the expected few thousand cycles
	initial begin
		repeat (40000) @(posedge clk_i);
		num_errors++;
		report_and_stop;
	end
endmodule // sfd_spi_port_tb_top
`default_nettype wire

// file: verilog/sfd_pkg.sv
// sfd_pkg: register map, field positions and reset values of the serial port.
// assumes a 32-bit classic wishbone slave, one register per aligned word.
package sfd_pkg;
	// register indices; byte address is four times the index
	localparam logic [2:0] IDX_CTRLA = 3'h0;
	localparam logic [2:0] IDX_CTRLB = 3'h1;
	localparam logic [2:0] IDX_IRQEN = 3'h2;
	localparam logic [2:0] IDX_FLAGS = 3'h3;
	localparam logic [2:0] IDX_DATA = 3'h4;
	// control A fields
	localparam int B_LSB_FIRST = 6;
	localparam int B_MASTER = 5;
	// control B fields
	localparam int B_BUF_EN = 7;
	localparam int B_SEL_DIS = 2;
	localparam int B_MODE_HI = 1;
	localparam int B_MODE_LO = 0;
	// enable and flag positions
	localparam int B_RXC = 7;
	localparam int B_TXC = 6;
	localparam int B_DRE = 5;
	localparam int B_SST = 4;
	localparam int B_IE = 0;
	localparam int B_IF = 7;
	localparam int B_WCOL = 6;
	localparam int B_OVF = 0;
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [4:0] HALVES_PER_BYTE = 5'h10;
	localparam int SYNC_STAGES = 3;
	localparam int N_SYNC = 4;
endpackage

// file: verilog/sfd_spi_port.sv
// sfd_spi_port: spi shifter, flags, interrupt enables and data port.
// assumes wishbone master on clk_i; serial pins come from another domain.
`timescale 1ns/1ns
`default_nettype none
module sfd_spi_port #(
	parameter int HALF_DIV = 4 // clk_i cycles per sck half period
) (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset, high
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write
	input wire logic [4:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte enables
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	output logic irq_o, // interrupt request
	input wire logic irq_ack_i, // vector taken pulse
	input wire logic sck_i, // sck pin in
	output logic sck_o, // sck pin out
	output logic sck_oe_o, // sck drive
	input wire logic sel_n_i, // slave select, low
	input wire logic mosi_i, // mosi pin in
	output logic mosi_o, // mosi pin out
	output logic mosi_oe_o, // mosi drive
	input wire logic miso_i, // miso pin in
	output logic miso_o, // miso pin out
	output logic miso_oe_o // miso drive
);
	////////////////////////////////////////////////////////////////
	logic [7:0] ctrla, ctrlb, irq_en, rxd, tx_sh, rx_sh, tx_buf, rd_byte;
	logic [7:0] rxb [2];
	logic [1:0] rx_cnt;
	logic [3:0] bit_cnt;
	logic [4:0] half_cnt;
	logic [15:0] div_cnt;
	logic [sfd_pkg::N_SYNC-1:0] s1, s2, s3, filt;
	logic mst, buf_en, sel_dis, cpol, cpha, lsb_first;
	logic acc, wr, rd, idx_hit_data, idx_hit_flags;
	logic running, sck_int, eff_prev, eff, edge_seen, lead, sample, setup;
	logic done, busy, sel_low, sdi, start_m, buf_load, norm_wr, new_xfer;
	logic if_flag, wcol, rxc, txc, sst, ovf, ovf_pend, tx_full, arm_if, arm_wc;
	logic pop, push, drop;
	localparam int SYNC_W = sfd_pkg::N_SYNC;
	localparam logic [15:0] DIV_LAST = 16'(HALF_DIV - 1);

	////////////////////////////////////////////////////////////////
	// pin synchronisers; a level counts once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < SYNC_W; g++) begin : g_sync
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					s1[g] <= 1'b1;
					s2[g] <= 1'b1;
					s3[g] <= 1'b1;
					filt[g] <= 1'b1;
				end else begin
					s1[g] <= (g == 0) ? sck_i : (g == 1) ? sel_n_i : (g == 2) ? mosi_i : miso_i;
					s2[g] <= s1[g];
					s3[g] <= s2[g];
					if (s2[g] == s3[g]) begin
						filt[g] <= s3[g];
					end
				end
			end
		end
	endgenerate

	assign mst = ctrla[sfd_pkg::B_MASTER];
	assign lsb_first = ctrla[sfd_pkg::B_LSB_FIRST];
	assign buf_en = ctrlb[sfd_pkg::B_BUF_EN];
	assign sel_dis = ctrlb[sfd_pkg::B_SEL_DIS];
	assign cpol = ctrlb[sfd_pkg::B_MODE_HI];
	assign cpha = ctrlb[sfd_pkg::B_MODE_LO];
	assign sel_low = !filt[1];
	assign sdi = mst ? filt[3] : filt[2];

	////////////////////////////////////////////////////////////////
	// bus decode; side effects happen on the acknowledged edge
	assign acc = wb_cyc_i && wb_stb_i && wb_ack_o;
	assign wr = acc && wb_we_i && wb_sel_i[0];
	assign rd = acc && !wb_we_i;
	assign idx_hit_data = wb_adr_i[4:2] == sfd_pkg::IDX_DATA;
	assign idx_hit_flags = wb_adr_i[4:2] == sfd_pkg::IDX_FLAGS;
	// normal data write goes to the shifter
	assign norm_wr = wr && idx_hit_data && !buf_en;
	assign pop = rd && idx_hit_data && buf_en && rx_cnt != 2'h0;
	// select low while master drops to slave
	assign drop = mst && sel_low && !sel_dis;

	// read mux; enables above bit 3 read zero outside buffer mode
	always_comb begin
		rd_byte = 8'h00;
		unique case (wb_adr_i[4:2])
			sfd_pkg::IDX_CTRLA: rd_byte = ctrla;
			sfd_pkg::IDX_CTRLB: rd_byte = ctrlb;
			sfd_pkg::IDX_IRQEN: rd_byte = buf_en ? irq_en : (irq_en & 8'h01);
			sfd_pkg::IDX_FLAGS: rd_byte = buf_en ? {rxc, txc, !tx_full, sst, 3'h0, ovf}
				: {if_flag, wcol, 6'h00};
			sfd_pkg::IDX_DATA: rd_byte = buf_en ? rxb[0] : rxd;
			default: rd_byte = 8'h00;
		endcase
	end

	// single wait state ack; unmapped addresses answer zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= {24'h000000, rd_byte};
		end
	end

	////////////////////////////////////////////////////////////////
	// control registers; the master bit also falls on select low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrla <= sfd_pkg::RST_REG;
			ctrlb <= sfd_pkg::RST_REG;
			irq_en <= sfd_pkg::RST_REG;
		end else begin
			if (wr && wb_adr_i[4:2] == sfd_pkg::IDX_CTRLA) begin
				ctrla <= wb_dat_i[7:0] & 8'h60;
			end else if (drop) begin
				ctrla[sfd_pkg::B_MASTER] <= 1'b0;
			end
			if (wr && wb_adr_i[4:2] == sfd_pkg::IDX_CTRLB) begin
				ctrlb <= wb_dat_i[7:0] & 8'h87;
			end
			if (wr && wb_adr_i[4:2] == sfd_pkg::IDX_IRQEN) begin
				irq_en <= wb_dat_i[7:0] & 8'hF1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// master clock generator: sixteen half periods per byte
	assign busy = mst ? running : (sel_low && bit_cnt != 4'h0);
	assign start_m = mst && !running && ((norm_wr) || buf_load);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			running <= 1'b0;
			sck_int <= 1'b0;
			half_cnt <= 5'h00;
			div_cnt <= 16'h0000;
		end else if (!mst || drop) begin
			running <= 1'b0;
			sck_int <= cpol;
		end else if (start_m) begin
			running <= 1'b1;
			half_cnt <= 5'h00;
			div_cnt <= 16'h0000;
			sck_int <= cpol;
		end else if (running) begin
			// stop one cycle after the last toggle, so its edge is still seen
			if (half_cnt == sfd_pkg::HALVES_PER_BYTE) begin
				running <= 1'b0;
			end else if (div_cnt == DIV_LAST) begin
				div_cnt <= 16'h0000;
				sck_int <= !sck_int;
				half_cnt <= half_cnt + 5'h01;
			end else begin
				div_cnt <= div_cnt + 16'h0001;
			end
		end else begin
			sck_int <= cpol;
		end
	end

	////////////////////////////////////////////////////////////////
	// edge finder on whichever clock drives the shifter
	assign eff = mst ? sck_int : filt[0];
	assign edge_seen = (eff != eff_prev) && (mst ? running : sel_low);
	assign lead = edge_seen && (eff != cpol);
	assign sample = cpha ? (edge_seen && !lead) : lead;
	assign setup = cpha ? lead : (edge_seen && !lead);
	assign done = sample && bit_cnt == sfd_pkg::BITS_PER_BYTE - 4'h1;
	assign new_xfer = start_m || (!mst && sample && bit_cnt == 4'h0);
	// slave loads staged byte between bytes, master only when idle
	assign buf_load = buf_en && tx_full && !busy && !(mst && running);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			eff_prev <= 1'b0;
		end else begin
			eff_prev <= eff;
		end
	end

	// shifters; the first bit of a byte is presented at load
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_sh <= sfd_pkg::RST_REG;
			rx_sh <= sfd_pkg::RST_REG;
			bit_cnt <= 4'h0;
		end else begin
			if (norm_wr && !busy) begin
				tx_sh <= wb_dat_i[7:0];
			end else if (buf_load) begin
				tx_sh <= tx_buf;
			end else if (setup && bit_cnt != 4'h0) begin
				tx_sh <= lsb_first ? {1'b0, tx_sh[7:1]} : {tx_sh[6:0], 1'b0};
			end
			if (!mst && !sel_low) begin
				bit_cnt <= 4'h0;
			end else if (sample) begin
				rx_sh <= lsb_first ? {sdi, rx_sh[7:1]} : {rx_sh[6:0], sdi};
				bit_cnt <= done ? 4'h0 : bit_cnt + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// receive register and two-entry buffer
	assign push = done && buf_en && (rx_cnt != 2'h2 || pop);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rxd <= sfd_pkg::RST_REG;
			rxb[0] <= sfd_pkg::RST_REG;
			rxb[1] <= sfd_pkg::RST_REG;
			rx_cnt <= 2'h0;
		end else begin
			if (done) begin
				rxd <= lsb_first ? {sdi, rx_sh[7:1]} : {rx_sh[6:0], sdi};
			end
			// pop shifts the back entry forward
			if (pop) begin
				rxb[0] <= rxb[1];
			end
			if (push) begin
				rxb[(pop ? rx_cnt - 2'h1 : rx_cnt) == 2'h0 ? 0 : 1] <=
					lsb_first ? {sdi, rx_sh[7:1]} : {rx_sh[6:0], sdi};
			end
			rx_cnt <= rx_cnt + {1'b0, push} - {1'b0, pop};
			if (!buf_en) begin
				rx_cnt <= 2'h0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_buf <= sfd_pkg::RST_REG;
			tx_full <= 1'b0;
		end else if (!buf_en) begin
			tx_full <= 1'b0;
		end else if (wr && idx_hit_data) begin
			// data write clears the empty flag
			tx_buf <= wb_dat_i[7:0];
			tx_full <= 1'b1;
		end else if (buf_load) begin
			tx_full <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// normal mode flags; flags read arms, data access clears, set wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			if_flag <= 1'b0;
			wcol <= 1'b0;
			arm_if <= 1'b0;
			arm_wc <= 1'b0;
		end else begin
			if (rd && idx_hit_flags && !buf_en) begin
				arm_if <= if_flag;
				arm_wc <= wcol;
			end else if (acc && idx_hit_data) begin
				arm_if <= 1'b0;
				arm_wc <= 1'b0;
			end
			// set on byte end or fall back; clears
			if ((done && !buf_en) || (drop && !buf_en)) begin
				if_flag <= 1'b1;
			end else if (irq_ack_i || (acc && idx_hit_data && arm_if)) begin
				if_flag <= 1'b0;
			end
			if (norm_wr && busy) begin
				wcol <= 1'b1;
			end else if (acc && idx_hit_data && arm_wc) begin
				wcol <= 1'b0;
			end
		end
	end

	// buffer mode flags; write one clears, hardware set wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rxc <= 1'b0;
			txc <= 1'b0;
			sst <= 1'b0;
			ovf <= 1'b0;
			ovf_pend <= 1'b0;
		end else begin
			if (push) begin
				rxc <= 1'b1;
			end else if ((pop && rx_cnt == 2'h1) || (wr && idx_hit_flags
				&& wb_dat_i[sfd_pkg::B_RXC])) begin
				rxc <= 1'b0;
			end
			if (done && buf_en && !tx_full) begin
				txc <= 1'b1;
			end else if (wr && idx_hit_flags && wb_dat_i[sfd_pkg::B_TXC]) begin
				txc <= 1'b0;
			end
			if (drop && buf_en) begin
				sst <= 1'b1;
			end else if (wr && idx_hit_flags && wb_dat_i[sfd_pkg::B_SST]) begin
				sst <= 1'b0;
			end
			// overflow held back until data waits or a transfer starts
			if (done && buf_en && rx_cnt == 2'h2 && !pop) begin
				ovf_pend <= 1'b1;
			end else if (tx_full || new_xfer) begin
				ovf_pend <= 1'b0;
			end
			if (ovf_pend && (tx_full || new_xfer)) begin
				ovf <= 1'b1;
			end else if ((rd && idx_hit_data) || (wr && idx_hit_flags
				&& wb_dat_i[sfd_pkg::B_OVF])) begin
				ovf <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// interrupt request and pins
	always_comb begin
		if (buf_en) begin
			irq_o = (irq_en[sfd_pkg::B_RXC] && rxc) || (irq_en[sfd_pkg::B_TXC] && txc)
				|| (irq_en[sfd_pkg::B_DRE] && !tx_full) || (irq_en[sfd_pkg::B_SST] && sst);
		end else begin
			irq_o = irq_en[sfd_pkg::B_IE] && if_flag;
		end
	end

	// master drives sck and mosi, selected slave drives miso
	assign sck_o = sck_int;
	assign sck_oe_o = mst;
	assign mosi_o = lsb_first ? tx_sh[0] : tx_sh[7];
	assign mosi_oe_o = mst;
	assign miso_o = lsb_first ? tx_sh[0] : tx_sh[7];
	assign miso_oe_o = !mst && sel_low;

	////////////////////////////////////////////////////////////////
	// checks
	sequence s_drop;
		mst && sel_low && !sel_dis;
	endsequence
	sequence s_busy_wr;
		norm_wr && busy;
	endsequence

	AST_IDLE_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
		mst && !running && $stable(cpol) |=> sck_o == $past(cpol))
		else $error("sck not at idle level");
	AST_BYTE_FLAG: assert property (@(posedge clk_i) disable iff (rst_i)
		done && !buf_en |=> if_flag)
		else $error("transfer flag not set after byte");
	AST_ACK_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_ack_i && !done && !drop |=> !if_flag)
		else $error("transfer flag survived acknowledge");
	AST_COLLIDE: assert property (@(posedge clk_i) disable iff (rst_i)
		s_busy_wr |=> wcol && ($stable(tx_sh) || $past(setup)))
		else $error("collision not flagged");
	AST_FALL_BACK: assert property (@(posedge clk_i) disable iff (rst_i)
		s_drop ##0 !wr |=> !mst && (if_flag || sst))
		else $error("master kept on select low");
	AST_SEL_DISABLE: assert property (@(posedge clk_i) disable iff (rst_i)
		mst && sel_dis && !(wr && wb_adr_i[4:2] == sfd_pkg::IDX_CTRLA) |=> mst)
		else $error("master lost with select disabled");
	AST_MASTER_START: assert property (@(posedge clk_i) disable iff (rst_i)
		start_m && !sel_low |=> running ##[1:300] done)
		else $error("master transfer did not run");
	AST_NORM_MASK: assert property (@(posedge clk_i) disable iff (rst_i)
		!buf_en && !if_flag |-> !irq_o)
		else $error("interrupt without transfer flag");
	AST_TX_STAGE: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && idx_hit_data && buf_en |=> tx_full)
		else $error("transmit buffer not staged");
endmodule // sfd_spi_port
`default_nettype wire
